// *** hdl/lihc_regs.svh ***
// Register map, field positions, reset values and timing counts of the
// line interface host control port. Definitions only; no logic here.
`ifndef LIHC_REGS_SVH
`define LIHC_REGS_SVH

// Command byte fields, first bit in is bit 0
`define LIHC_CMD_DIR 0
`define LIHC_CMD_ADDR_LSB 1
`define LIHC_CMD_ADDR_MSB 6
`define LIHC_REG_ADDR 6'h10

// Control word fields
`define LIHC_W_CLEAR_LOSS_ALARM 0
`define LIHC_W_CLEAR_DRIVER_ALARM 1
`define LIHC_W_LEN_LSB 2
`define LIHC_W_LEN_MSB 4
`define LIHC_W_REMOTE_LOOPBACK 5
`define LIHC_W_LOCAL_LOOPBACK 6
`define LIHC_W_TRANSMIT_ALL_ONES 7

// Status word fields
`define LIHC_S_LOS 0
`define LIHC_S_DPM 1

// Reset values
`define LIHC_CTRL_RESET 8'h00
`define LIHC_STAT_RESET 8'h00

// Serial bit counter landmarks (rising edges seen)
`define LIHC_CNT_LAST_CMD 5'd7
`define LIHC_CNT_LAST_WBIT 5'd15
`define LIHC_CNT_RD_END 5'd16
`define LIHC_CNT_MAX 5'd17

// Driver monitor timeout
`define LIHC_MCLK_NS 10
`define LIHC_MON_TIMEOUT_NS 20000
`define LIHC_MON_CYCLES (`LIHC_MON_TIMEOUT_NS / `LIHC_MCLK_NS)

`endif

// *** hdl/lihc_pkg.sv ***
// Types shared by the line interface host control port.
// Assumes the register header sits beside it.
package lihc_pkg;
  // Line code selection, one-hot
  typedef enum logic [2:0]
  {
    lihc_ami = 3'b001,
    lihc_hdb3 = 3'b010,
    lihc_b8zs = 3'b100
  } lihc_code_t;

  // Operating state held by the control logic
  typedef struct packed {
    logic [2:0] len;
    logic remote_loopback;
    logic local_loopback;
    logic transmit_all_ones;
    logic transmit_coding_select;
    logic receive_coding_select;
  } lihc_ctrl_t;
endpackage

// *** hdl/lihc_top.sv ***
// Control, status and serial host port of a T1/E1 line interface.
// Assumes i_mclk at 100 MHz; serial clock i_sclk only runs while i_cs_b is low.
//
// How it works
// - Transmit coding: AMI, HDB3 or B8ZS by length
// - Receive decoder gives data and violation strobe
// - Parallel controls accepted only while gate low
// - Driver alarm rises when monitor shows no activity
// - Driver alarm on pin and status bit
// - Serial input sampled on rising serial clock
// - Read bit relaunched from the snapshot on every output edge
// - Serial output floats when idle or done
// - First command bit: 0 write, 1 read
// - Address 16 only; last command bit ignored
// - Write data: eight clocks after command, LSB first
// - Control word layout: clears, length, loops, ones
// - Clear bit drops interrupt and masks source
// - Reading status leaves interrupt pending
// - Writing zero to clear bit unmasks source
// - Remote loop with all ones enters test mode
// - Status bits: loss, driver, line length
// - Status bits 5..7 carry the state code
// - Interrupt asserts on unmasked alarm change
// - Output edge select picks serial output edge
// - Writing both loopbacks resets control, test mode, masks and pending flags
`timescale 1ns/1ps
`include "lihc_regs.svh"

module lihc_top
  import lihc_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Mode strap and parallel controls
  input wire logic i_host_mode,
  input wire logic i_parallel_control_gate_b,
  input wire logic i_transmit_coding_select,
  input wire logic i_receive_coding_select,
  input wire logic [2:0] i_line_length_sel,
  input wire logic i_remote_loopback,
  input wire logic i_local_loopback,
  input wire logic i_transmit_all_ones,
  input wire logic i_output_edge_select,
  // Line status inputs
  input wire logic i_monitor_input_pos,
  input wire logic i_monitor_input_neg,
  input wire logic i_signal_loss_alarm,
  // Receive rails and symbol clock
  input wire logic i_rx_pos,
  input wire logic i_rx_neg,
  input wire logic i_rx_sym_clk,
  // Serial host port
  input wire logic i_sclk,
  input wire logic i_cs_b,
  input wire logic i_port_serial_in,
  output logic o_port_serial_out,
  output logic o_port_serial_out_oe,
  // Operating state
  output lihc_code_t o_tx_code,
  output lihc_code_t o_rx_code,
  output logic [2:0] o_line_length,
  output logic o_remote_loopback,
  output logic o_local_loopback,
  output logic o_transmit_all_ones,
  output logic o_factory_test,
  // Alarms, open-drain interrupt
  output logic o_driver_monitor_alarm,
  output logic o_int_out,
  output logic o_int_oe,
  // Decoded receive data
  output logic o_rx_data,
  output logic o_rx_valid,
  output logic o_bipolar_violation_strobe
);

  // Pin synchronisers, all pins but the two clocks, reset, serial input and edge select enter through two flops
  localparam int NPIN = 17;
  logic [NPIN-1:0] pin_meta_reg; // First stage, read only by second
  logic [NPIN-1:0] pin_sync_reg; // Second stage
  wire [NPIN-1:0] pin_raw = {i_host_mode, i_parallel_control_gate_b,
    i_transmit_coding_select, i_receive_coding_select, i_line_length_sel,
    i_remote_loopback, i_local_loopback, i_transmit_all_ones,
    i_monitor_input_pos, i_monitor_input_neg, i_signal_loss_alarm,
    i_rx_pos, i_rx_neg, i_rx_sym_clk, i_cs_b};

  // Two-flop capture of every pin in pin_raw
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end
    else
    begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Named views of the synchronised pins
  wire host_s = pin_sync_reg[16];
  wire gate_b_s = pin_sync_reg[15];
  wire transmit_coding_select_s = pin_sync_reg[14];
  wire receive_coding_select_s = pin_sync_reg[13];
  wire [2:0] len_s = pin_sync_reg[12:10];
  wire remote_loopback_s = pin_sync_reg[9];
  wire local_loopback_s = pin_sync_reg[8];
  wire transmit_all_ones_s = pin_sync_reg[7];
  wire mpos_s = pin_sync_reg[6];
  wire mneg_s = pin_sync_reg[5];
  wire los_s = pin_sync_reg[4];
  wire rxp_s = pin_sync_reg[3];
  wire rxn_s = pin_sync_reg[2];
  wire rxclk_s = pin_sync_reg[1];
  wire cs_b_s = pin_sync_reg[0];

  // Serial clock domain
  // Cleared whenever chip select is high, so each frame starts at bit 0
  wire ser_clr = i_cs_b | ~i_rst_b;
  logic [4:0] bit_cnt_reg; // Rising edges seen in this frame
  logic [7:0] shift_reg; // Incoming bits, LSB first
  logic [7:0] cmd_reg; // Latched command byte
  logic [7:0] snap_reg; // Status frozen for this read
  logic pos_d_reg; // Output launched on rising edge
  logic pos_oe_reg;
  logic neg_d_reg; // Output launched on falling edge
  logic neg_oe_reg;
  logic wr_tgl_reg; // Flips once per accepted write
  logic [7:0] wdata_reg; // Last written control word
  logic [7:0] shadow_reg; // Status copy, frozen while selected

  // Command decode
  wire [7:0] shift_next = {i_port_serial_in, shift_reg[7:1]};
  wire addr_hit = cmd_reg[`LIHC_CMD_ADDR_MSB:`LIHC_CMD_ADDR_LSB] == `LIHC_REG_ADDR;
  wire cmd_rd = cmd_reg[`LIHC_CMD_DIR] & addr_hit;
  wire last_wbit = (bit_cnt_reg == `LIHC_CNT_LAST_WBIT) & ~cmd_reg[`LIHC_CMD_DIR] & addr_hit;
  wire rd_slot = (bit_cnt_reg[4:3] == 2'b01) & cmd_rd;
  wire rd_bit = snap_reg[bit_cnt_reg[2:0]];

  // Bit counter, shifter and command latch on rising serial clock
  always_ff @(posedge i_sclk or posedge ser_clr)
  begin
    if (ser_clr)
    begin
      bit_cnt_reg <= 5'h00;
      shift_reg <= 8'h00;
      cmd_reg <= 8'h00;
      snap_reg <= 8'h00;
    end
    else
    begin
      // Saturate so late clocks do nothing
      if (bit_cnt_reg != `LIHC_CNT_MAX)
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
      shift_reg <= shift_next;
      // Command complete: bit 7 is kept but never decoded
      if (bit_cnt_reg == `LIHC_CNT_LAST_CMD)
      begin
        cmd_reg <= shift_next;
        snap_reg <= shadow_reg;
      end
    end
  end

  // Read data launched on rising edges, for valid-on-falling
  always_ff @(posedge i_sclk or posedge ser_clr)
  begin
    if (ser_clr)
    begin
      pos_d_reg <= 1'b0;
      pos_oe_reg <= 1'b0;
    end
    else
    begin
      pos_d_reg <= rd_bit;
      pos_oe_reg <= rd_slot;
    end
  end

  // Read data launched on falling edges, for valid-on-rising
  always_ff @(negedge i_sclk or posedge ser_clr)
  begin
    if (ser_clr)
    begin
      neg_d_reg <= 1'b0;
      neg_oe_reg <= 1'b0;
    end
    else
    begin
      neg_d_reg <= rd_bit;
      neg_oe_reg <= rd_slot;
    end
  end

  // Edge choice is a strap, expected static while selected
  assign o_port_serial_out = i_output_edge_select ? neg_d_reg : pos_d_reg;
  assign o_port_serial_out_oe = i_output_edge_select ? neg_oe_reg : pos_oe_reg;

  // Write capture survives chip select, so only the main reset clears it
  always_ff @(posedge i_sclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      wr_tgl_reg <= 1'b0;
      wdata_reg <= `LIHC_CTRL_RESET;
    end
    else if (!i_cs_b && last_wbit)
    begin
      wr_tgl_reg <= ~wr_tgl_reg;
      wdata_reg <= shift_next;
    end
  end

  // Main clock domain
  logic wr_meta_reg; // First stage of the write toggle
  logic wr_sync_reg;
  logic wr_seen_reg;
  wire wr_pulse = wr_sync_reg ^ wr_seen_reg;
  // Word held stable by the toggle handshake; host spaces writes widely
  wire host_wr = wr_pulse & host_s;
  wire host_rst = host_wr & wdata_reg[`LIHC_W_REMOTE_LOOPBACK] & wdata_reg[`LIHC_W_LOCAL_LOOPBACK];

  // Toggle crossing of write events
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      wr_meta_reg <= 1'b0;
      wr_sync_reg <= 1'b0;
      wr_seen_reg <= 1'b0;
    end
    else
    begin
      wr_meta_reg <= wr_tgl_reg;
      wr_sync_reg <= wr_meta_reg;
      wr_seen_reg <= wr_sync_reg;
    end
  end

  // Operating state
  lihc_ctrl_t ctrl_reg;
  lihc_ctrl_t ctrl_next;
  logic test_reg;
  logic test_next;

  // Next control state from serial write or gated pins
  always_comb
  begin
    ctrl_next = ctrl_reg;
    test_next = test_reg;
    if (host_wr)
    begin
      ctrl_next.len = wdata_reg[`LIHC_W_LEN_MSB:`LIHC_W_LEN_LSB];
      ctrl_next.remote_loopback = wdata_reg[`LIHC_W_REMOTE_LOOPBACK];
      ctrl_next.local_loopback = wdata_reg[`LIHC_W_LOCAL_LOOPBACK];
      ctrl_next.transmit_all_ones = wdata_reg[`LIHC_W_TRANSMIT_ALL_ONES];
      test_next = wdata_reg[`LIHC_W_REMOTE_LOOPBACK] & wdata_reg[`LIHC_W_TRANSMIT_ALL_ONES];
    end
    else if (!host_s && !gate_b_s)
    begin
      // Gate low: pins pass straight through every cycle
      ctrl_next = '{len: len_s, remote_loopback: remote_loopback_s, local_loopback: local_loopback_s, transmit_all_ones: transmit_all_ones_s,
                    transmit_coding_select: transmit_coding_select_s, receive_coding_select: receive_coding_select_s};
    end
    if (host_rst)
    begin
      ctrl_next = `LIHC_CTRL_RESET;
      test_next = 1'b0;
    end
  end

  // Line code choice from select pin and length
  function automatic lihc_code_t code_pick(input logic sel, input logic [2:0] len);
    if (sel)
      code_pick = lihc_ami;
    else if (len == 3'h0)
      code_pick = lihc_hdb3;
    else if (len == 3'h1)
      code_pick = lihc_ami; // Unlisted length, plain AMI
    else
      code_pick = lihc_b8zs;
  endfunction

  wire lihc_code_t tx_code_w = code_pick(ctrl_reg.transmit_coding_select, ctrl_reg.len);
  wire lihc_code_t rx_code_w = code_pick(ctrl_reg.receive_coding_select, ctrl_reg.len);

  // Control registers and derived outputs
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ctrl_reg <= `LIHC_CTRL_RESET;
      test_reg <= 1'b0;
      o_tx_code <= lihc_hdb3;
      o_rx_code <= lihc_hdb3;
      o_line_length <= 3'h0;
      o_remote_loopback <= 1'b0;
      o_local_loopback <= 1'b0;
      o_transmit_all_ones <= 1'b0;
      o_factory_test <= 1'b0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      test_reg <= test_next;
      o_tx_code <= tx_code_w;
      o_rx_code <= rx_code_w;
      o_line_length <= ctrl_reg.len;
      o_remote_loopback <= ctrl_reg.remote_loopback;
      o_local_loopback <= ctrl_reg.local_loopback;
      o_transmit_all_ones <= ctrl_reg.transmit_all_ones;
      o_factory_test <= test_reg;
    end
  end

  // Driver activity monitor
  logic act_prev_reg; // Last threshold state
  logic [15:0] mon_cnt_reg; // Cycles since last threshold crossing
  logic dpm_reg;
  wire act_w = mpos_s | mneg_s;
  wire mon_edge = act_w ^ act_prev_reg;
  wire mon_out = mon_cnt_reg == 16'(`LIHC_MON_CYCLES);

  // Timeout counter restarts on every crossing either way
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      act_prev_reg <= 1'b0;
      mon_cnt_reg <= 16'h0000;
      dpm_reg <= 1'b0;
    end
    else
    begin
      act_prev_reg <= act_w;
      if (mon_edge)
        mon_cnt_reg <= 16'h0000;
      else if (!mon_out)
        mon_cnt_reg <= mon_cnt_reg + 16'h0001;
      dpm_reg <= mon_out & ~mon_edge;
    end
  end

  // Interrupt sources, masks and pending flags
  logic los_prev_reg;
  logic dpm_prev_reg;
  logic los_mask_reg;
  logic dpm_mask_reg;
  logic los_pend_reg;
  logic dpm_pend_reg;
  wire los_chg = los_s ^ los_prev_reg;
  wire dpm_chg = dpm_reg ^ dpm_prev_reg;
  wire clear_loss_alarm = host_wr & wdata_reg[`LIHC_W_CLEAR_LOSS_ALARM];
  wire clear_driver_alarm = host_wr & wdata_reg[`LIHC_W_CLEAR_DRIVER_ALARM];
  // A change landing with its clear still sets the flag
  wire los_pend_next = (los_chg & ~los_mask_reg) | (los_pend_reg & ~clear_loss_alarm);
  wire dpm_pend_next = (dpm_chg & ~dpm_mask_reg) | (dpm_pend_reg & ~clear_driver_alarm);

  // Pending flags only move on change or write, never on read
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      los_prev_reg <= 1'b0;
      dpm_prev_reg <= 1'b0;
      los_mask_reg <= 1'b0;
      dpm_mask_reg <= 1'b0;
      los_pend_reg <= 1'b0;
      dpm_pend_reg <= 1'b0;
    end
    else
    begin
      los_prev_reg <= los_s;
      dpm_prev_reg <= dpm_reg;
      if (host_rst)
      begin
        los_mask_reg <= 1'b0;
        dpm_mask_reg <= 1'b0;
        los_pend_reg <= 1'b0;
        dpm_pend_reg <= 1'b0;
      end
      else
      begin
        // One masks the source, zero opens it again
        if (host_wr)
        begin
          los_mask_reg <= wdata_reg[`LIHC_W_CLEAR_LOSS_ALARM];
          dpm_mask_reg <= wdata_reg[`LIHC_W_CLEAR_DRIVER_ALARM];
        end
        los_pend_reg <= los_pend_next;
        dpm_pend_reg <= dpm_pend_next;
      end
    end
  end

  // Status word, bit 5 is the first digit of the code
  wire any_pend = los_pend_reg | dpm_pend_reg;
  wire [2:0] code_w = any_pend ? {1'b1, los_pend_reg, dpm_pend_reg} :
    ctrl_reg.remote_loopback ? 3'b100 : {1'b0, ctrl_reg.local_loopback, ctrl_reg.transmit_all_ones};
  wire [7:0] stat_w = {code_w[0], code_w[1], code_w[2], ctrl_reg.len,
    dpm_reg, los_s};

  // Alarm pins and the status copy the serial side reads
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_driver_monitor_alarm <= 1'b0;
      o_int_out <= 1'b0;
      o_int_oe <= 1'b0;
      shadow_reg <= `LIHC_STAT_RESET;
    end
    else
    begin
      o_driver_monitor_alarm <= dpm_reg;
      o_int_out <= 1'b0; // Open drain only pulls low
      o_int_oe <= any_pend;
      // Frozen once selected so the serial side sees a steady word
      if (cs_b_s)
        shadow_reg <= stat_w;
    end
  end

  // Receive decoder: eight-symbol delay lets substitutions be undone
  logic rxclk_prev_reg;
  logic [7:0] d_reg; // Marks, newest at bit 0
  logic [7:0] b_reg; // Violation flags alongside
  logic last_pol_reg; // Polarity of previous mark
  logic seen_reg; // A mark has been seen
  logic kill_reg; // Drop the next mark (B8ZS tail)
  wire sym = rxclk_s & ~rxclk_prev_reg;
  wire mark = rxp_s | rxn_s;
  wire viol = mark & seen_reg & (rxp_s == last_pol_reg) & ~kill_reg;
  wire sub8 = viol & (o_rx_code == lihc_b8zs) & ~d_reg[0] & d_reg[1] & ~b_reg[1] &
    d_reg[2] & b_reg[2] & (d_reg[5:3] == 3'h0);
  wire sub3 = viol & (o_rx_code == lihc_hdb3) & (d_reg[1:0] == 2'h0);
  wire sub = sub8 | sub3;
  wire [7:0] d_cl = d_reg & ~(sub8 ? 8'h06 : sub3 ? 8'h04 : 8'h00);
  wire [7:0] b_cl = b_reg & ~(sub8 ? 8'h04 : 8'h00);

  // Decoder pipeline advances once per received symbol
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rxclk_prev_reg <= 1'b0;
      d_reg <= 8'h00;
      b_reg <= 8'h00;
      last_pol_reg <= 1'b0;
      seen_reg <= 1'b0;
      kill_reg <= 1'b0;
      o_rx_data <= 1'b0;
      o_rx_valid <= 1'b0;
      o_bipolar_violation_strobe <= 1'b0;
    end
    else
    begin
      rxclk_prev_reg <= rxclk_s;
      o_rx_valid <= sym;
      o_bipolar_violation_strobe <= sym & b_cl[7];
      if (sym)
      begin
        d_reg <= {d_cl[6:0], mark & ~kill_reg & ~sub};
        b_reg <= {b_cl[6:0], viol & ~sub};
        o_rx_data <= d_cl[7];
        kill_reg <= sub8;
        if (mark)
        begin
          last_pol_reg <= rxp_s;
          seen_reg <= 1'b1;
        end
      end
    end
  end

  // Checks
  sequence s_wbit_done;
    last_wbit;
  endsequence

  sequence s_gate_shut;
    !host_s && gate_b_s && !wr_pulse;
  endsequence

  gate_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    s_gate_shut |=> $stable(ctrl_reg))
    else $error("controls changed while gate high");

  tx_hdb3_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (!ctrl_reg.transmit_coding_select && ctrl_reg.len == 3'h0) |=> o_tx_code == lihc_hdb3)
    else $error("transmit code not HDB3");

  tx_b8zs_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (!ctrl_reg.transmit_coding_select && ctrl_reg.len[2:1] != 2'h0) |=> o_tx_code == lihc_b8zs)
    else $error("transmit code not B8ZS");

  mon_timeout_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (mon_out && !mon_edge) |-> ##2 o_driver_monitor_alarm)
    else $error("driver alarm missed timeout");

  int_raise_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (los_chg && !los_mask_reg && !host_rst) |-> ##2 o_int_oe)
    else $error("interrupt not raised");

  // A change landing with the clear keeps the flag set, so it is left out here
  clr_mask_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (clear_loss_alarm && !los_chg && !host_rst) |=> los_mask_reg && !los_pend_reg)
    else $error("clear did not mask");

  read_keep_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (los_pend_reg && !host_wr) |=> los_pend_reg)
    else $error("pending flag lost");

  host_reset_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    host_rst |=> (ctrl_reg == `LIHC_CTRL_RESET) && !test_reg)
    else $error("loopback pair did not reset");

  wr_accept_a: assert property (@(posedge i_sclk) disable iff (ser_clr)
    s_wbit_done |=> $changed(wr_tgl_reg))
    else $error("write not accepted");

  rd_float_a: assert property (@(posedge i_sclk) disable iff (ser_clr)
    (bit_cnt_reg >= `LIHC_CNT_RD_END) |=> !pos_oe_reg)
    else $error("output driven after last bit");

endmodule

// *** tb/lihc_host.sv ***
// Host controller model on the serial control port.
// Assumes the bench resolves the released output line.
`timescale 1ns/1ps
module lihc_host
(
  // Serial pins
  output logic o_sclk,
  output logic o_cs_b,
  output logic o_sdi,
  // Returned data and strap
  input wire logic i_sdo,
  input wire logic i_sdo_oe,
  input wire logic i_edge_sel
);
  // Clock stands low outside frames
  initial
  begin
    o_sclk = 1'b0;
    o_cs_b = 1'b1;
    o_sdi = 1'b0;
  end

  // Whole frame: command byte, then data byte
  task automatic xfer(input logic [7:0] c, input logic [7:0] d, output logic [7:0] r, output logic z);
    begin
      o_cs_b = 1'b0;
      #20;
      for (int i = 0; i < 16; i++)
      begin
        // Bit set up half a period before the rise
        o_sdi = (i < 8) ? c[i[2:0]] : d[i[2:0]];
        #15;
        if (i >= 8 && i_edge_sel)
          r[i[2:0]] = i_sdo;
        o_sclk = 1'b1;
        #15;
        if (i >= 8 && !i_edge_sel)
          r[i[2:0]] = i_sdo;
        o_sclk = 1'b0;
      end
      // Extra edge shows the output let go
      #15;
      o_sclk = 1'b1;
      #5;
      z = i_sdo_oe;
      #10;
      o_sclk = 1'b0;
      // Well past the 50 ns hold after the last bit
      #60;
      o_cs_b = 1'b1;
      o_sdi = ~o_sdi;
      #60;
    end
  endtask
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the line interface host control port.
// Assumes the host model owns the serial pins.
`timescale 1ns/1ps
module testbench
  import lihc_pkg::*;
;
  // Pins driven by the bench
  logic i_mclk = 1'b0;
  logic rst_b = 1'b0;
  logic hmode = 1'b0;
  logic gate_b = 1'b1;
  logic tcs = 1'b0;
  logic rcs = 1'b0;
  logic [2:0] len = 3'h0;
  logic [2:0] pl = 3'h0;
  logic esel = 1'b1;
  logic mpos = 1'b0;
  logic mneg = 1'b0;
  logic signal_loss_alarm = 1'b0;
  logic act = 1'b1;
  // Receive rails and symbol clock
  logic rxp = 1'b0;
  logic rxn = 1'b0;
  logic rxck = 1'b0;
  // Serial wires; a released output shows the inverse of its last bit
  wire sclk, cs_b, port_serial_in, port_serial_out, oe;
  wire sdo_w = oe ? port_serial_out : ~port_serial_out;
  // Design outputs
  lihc_code_t tx, rx;
  logic [2:0] olen;
  logic orl, oll, otaos, ofact, odpm, ioe;
  logic rxd, rxv, bipolar_violation_strobe, iout;
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  // Decoder output tallies
  int n_rxv = 0;
  int n_one = 0;
  int n_bpv = 0;

  lihc_top dut
  (
    .i_mclk(i_mclk), .i_rst_b(rst_b), .i_host_mode(hmode),
    .i_parallel_control_gate_b(gate_b), .i_transmit_coding_select(tcs),
    .i_receive_coding_select(rcs), .i_line_length_sel(len),
    .i_remote_loopback(pl[2]), .i_local_loopback(pl[1]), .i_transmit_all_ones(pl[0]),
    .i_output_edge_select(esel), .i_monitor_input_pos(mpos), .i_monitor_input_neg(mneg),
    .i_signal_loss_alarm(signal_loss_alarm), .i_rx_pos(rxp), .i_rx_neg(rxn), .i_rx_sym_clk(rxck),
    .i_sclk(sclk), .i_cs_b(cs_b), .i_port_serial_in(port_serial_in),
    .o_port_serial_out(port_serial_out), .o_port_serial_out_oe(oe),
    .o_tx_code(tx), .o_rx_code(rx), .o_line_length(olen),
    .o_remote_loopback(orl), .o_local_loopback(oll), .o_transmit_all_ones(otaos),
    .o_factory_test(ofact), .o_driver_monitor_alarm(odpm),
    .o_int_out(iout), .o_int_oe(ioe),
    .o_rx_data(rxd), .o_rx_valid(rxv), .o_bipolar_violation_strobe(bipolar_violation_strobe)
  );

  lihc_host host
  (
    .o_sclk(sclk), .o_cs_b(cs_b), .o_sdi(port_serial_in),
    .i_sdo(sdo_w), .i_sdo_oe(oe), .i_edge_sel(esel)
  );

  // Main clock
  always #5 i_mclk = ~i_mclk;

  // Pulses on each rail with idle between, so the threshold is crossed both ways
  always @(negedge i_mclk)
  begin
    if (act)
    begin
      mpos <= (cyc[6:5] == 2'h1);
      mneg <= (cyc[6:5] == 2'h3);
    end
  end

  // Decoder pulses last one cycle, so the falling edge sees each once
  always @(negedge i_mclk)
  begin
    if (rxv)
    begin
      n_rxv <= n_rxv + 1;
      n_one <= n_one + int'(rxd);
      n_bpv <= n_bpv + int'(bipolar_violation_strobe);
    end
  end

  // Hang guard, well above the expected run
  always @(posedge i_mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      miscompares = miscompares + 1;
      complete_run;
    end
  end

  task automatic w(input int n);
    repeat (n) @(negedge i_mclk);
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    begin
      n_tests++;
      if (g !== e)
      begin
        $display("unexpected %s: expected %h seen %h", nm, e, g);
        miscompares++;
      end
    end
  endtask

  // Write frame, then let it cross into the main domain
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    logic z;
    begin
      host.xfer(c, d, r, z);
      w(10);
    end
  endtask

  // Read frame at address 16
  task automatic rd(input logic [7:0] e);
    logic [7:0] r;
    logic z;
    begin
      host.xfer(8'h21, 8'h00, r, z);
      chk("status", e, r);
      chk("oe after last bit", 8'h00, 8'(z));
      chk("oe after cs", 8'h00, 8'(oe));
    end
  endtask

  // Parallel pins in extended mode
  task automatic t_ext;
    begin
      chk("tx reset", 8'(lihc_hdb3), 8'(tx));
      gate_b = 1'b0;
      rcs = 1'b1;
      pl = 3'h1;
      w(8);
      chk("tx hdb3", 8'(lihc_hdb3), 8'(tx));
      chk("rx ami", 8'(lihc_ami), 8'(rx));
      chk("ones", 8'h01, 8'(otaos));
      gate_b = 1'b1;
      w(4);
      len = 3'h2;
      rcs = 1'b0;
      gate_b = 1'b0;
      w(8);
      chk("tx b8zs", 8'(lihc_b8zs), 8'(tx));
      chk("rx b8zs", 8'(lihc_b8zs), 8'(rx));
      gate_b = 1'b1;
      w(4);
      tcs = 1'b1;
      pl = 3'h0;
      w(8);
      chk("tx gated", 8'(lihc_b8zs), 8'(tx));
      chk("ones gated", 8'h01, 8'(otaos));
      gate_b = 1'b0;
      w(8);
      chk("tx ami", 8'(lihc_ami), 8'(tx));
      gate_b = 1'b1;
    end
  endtask

  // Host write and read back on both output edges
  task automatic t_host;
    begin
      hmode = 1'b1;
      w(4);
      wr(8'h20, 8'h94);
      chk("length", 8'h05, 8'(olen));
      chk("ones", 8'h01, 8'(otaos));
      chk("dpm rest", 8'h00, 8'(odpm));
      rd(8'h94);
      esel = 1'b0;
      w(2);
      rd(8'h94);
      wr(8'h22, 8'h00);
      chk("length kept", 8'h05, 8'(olen));
    end
  endtask

  // Test mode code, then host reset
  task automatic t_fact;
    begin
      wr(8'h20, 8'ha0);
      chk("test mode", 8'h01, 8'(ofact));
      chk("remote", 8'h01, 8'(orl));
      rd(8'h20);
      wr(8'h20, 8'h74);
      chk("test cleared", 8'h00, 8'(ofact));
      chk("length cleared", 8'h00, 8'(olen));
      rd(8'h00);
    end
  endtask

  // Interrupt set, read, clear, mask, unmask
  task automatic t_irq;
    begin
      wr(8'h20, 8'h00);
      signal_loss_alarm = 1'b1;
      w(6);
      chk("int set", 8'h01, 8'(ioe));
      chk("int level", 8'h00, 8'(iout));
      rd(8'h61);
      chk("int after read", 8'h01, 8'(ioe));
      wr(8'h20, 8'h01);
      chk("int cleared", 8'h00, 8'(ioe));
      rd(8'h01);
      signal_loss_alarm = 1'b0;
      w(6);
      chk("int masked", 8'h00, 8'(ioe));
      wr(8'h20, 8'h00);
      signal_loss_alarm = 1'b1;
      w(6);
      chk("int unmasked", 8'h01, 8'(ioe));
      wr(8'h20, 8'h01);
    end
  endtask

  // Marks + - + + then zeros: the fourth mark breaks alternation
  task automatic t_rx;
    begin
      for (int i = 0; i < 12; i++)
      begin
        rxp = (i == 0) || (i == 2) || (i == 3);
        rxn = (i == 1);
        w(3);
        rxck = 1'b1;
        w(3);
        rxck = 1'b0;
      end
      w(4);
      chk("rx symbols", 8'h0c, 8'(n_rxv));
      chk("rx ones", 8'h04, 8'(n_one));
      chk("rx violations", 8'h01, 8'(n_bpv));
    end
  endtask

  // Monitor starved past the timeout
  task automatic t_dpm;
    begin
      act = 1'b0;
      w(2200);
      chk("dpm", 8'h01, 8'(odpm));
      rd(8'ha3);
      chk("int dpm", 8'h01, 8'(ioe));
    end
  endtask

  task automatic complete_run;
    begin
      if (miscompares == 0 && n_tests > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  initial
  begin
    w(2);
    rst_b = 1'b1;
    w(4);
    t_ext;
    t_host;
    t_fact;
    t_irq;
    t_rx;
    t_dpm;
    complete_run;
  end
endmodule
